/* File: design/lbs_sequencer.sv */
// register file and blink sequencer for led channels a and b
`timescale 1ns/1ps
`include "lbs_params.svh"

// Summary of operation
// - reserved bits read zero and ignore writes
// - channel a on-duration is five bits, value times 64 ms
// - channel b ramp enable at bit 5; one enables current ramping
// - channel b sink level in bits 3:0 goes to the sink driver
// - channel b phase one length seven bits, value times 64 ms
// - channel b phase two length seven bits, value times 64 ms
// - channel b phase three length seven bits, value times 64 ms
// - channel b phase four length seven bits, value times 64 ms
// - all registers clear to zero on reset
// - drive signal pwm over 8 ms, high for duty plus one of 32 slots
// - pattern period is seven bits, value plus one times 64 ms
module lbs_sequencer import lbs_pkg::*; #(
    parameter int unsigned STEP_CYCLES = `LBS_STEP_CYCLES,
    parameter int unsigned SLOT_CYCLES = `LBS_SLOT_CYCLES
) (
    // clock and reset
    input  wire logic        ref_clk_i,
    input  wire logic        resetn_i,
    // apb slave
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [11:0] paddr_i,
    input  wire logic [31:0] pwdata_i,
    input  wire logic [3:0]  pstrb_i,
    output logic      [31:0] prdata_o,
    output logic             pready_o,
    output logic             pslverr_o,
    // led outputs
    output logic             chan_a_drive_signal_o,
    output logic      [3:0]  chan_b_sink_level_o,
    output logic             chan_b_ramp_on_o,
    output logic      [2:0]  chan_b_phase_o
);

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function automatic logic [11:0] byte_addr(input logic [7:0] idx);
        byte_addr = {2'b00, idx, 2'b00};
    endfunction

    function automatic logic hit(input logic [11:0] a, input logic [7:0] idx);
        hit = (a == byte_addr(idx));
    endfunction

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    logic [7:0] a_on_dur_q;
    logic [7:0] b_ramp_cur_q;
    logic [7:0] b_ph_q [4];
    logic [7:0] a_duty_q;
    logic [7:0] a_period_q;

    wire        acc_w      = psel_i & penable_i;
    wire        wr_w       = acc_w & pwrite_i & pstrb_i[0];
    wire        hit_on_w   = hit(paddr_i, `LBS_IDX_A_ON_DUR);
    wire        hit_rc_w   = hit(paddr_i, `LBS_IDX_B_RAMP_CUR);
    wire        hit_p1_w   = hit(paddr_i, `LBS_IDX_B_PH1);
    wire        hit_p2_w   = hit(paddr_i, `LBS_IDX_B_PH2);
    wire        hit_p3_w   = hit(paddr_i, `LBS_IDX_B_PH3);
    wire        hit_p4_w   = hit(paddr_i, `LBS_IDX_B_PH4);
    wire        hit_du_w   = hit(paddr_i, `LBS_IDX_A_DUTY);
    wire        hit_pe_w   = hit(paddr_i, `LBS_IDX_A_PERIOD);
    wire        hit_st_w   = hit(paddr_i, `LBS_IDX_STATUS);
    wire        mapped_w   = hit_on_w | hit_rc_w | hit_p1_w | hit_p2_w | hit_p3_w
                           | hit_p4_w | hit_du_w | hit_pe_w | hit_st_w;
    wire [7:0]  wbyte_w    = pwdata_i[7:0];

    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            a_on_dur_q   <= `LBS_REG_RESET;
            b_ramp_cur_q <= `LBS_REG_RESET;
            b_ph_q[0]    <= `LBS_REG_RESET;
            b_ph_q[1]    <= `LBS_REG_RESET;
            b_ph_q[2]    <= `LBS_REG_RESET;
            b_ph_q[3]    <= `LBS_REG_RESET;
            a_duty_q     <= `LBS_REG_RESET;
            a_period_q   <= `LBS_REG_RESET;
        end else if (wr_w) begin
            if (hit_on_w) a_on_dur_q   <= wbyte_w & `LBS_ON_DUR_MASK;
            if (hit_rc_w) b_ramp_cur_q <= wbyte_w & `LBS_RAMP_CUR_MASK;
            if (hit_p1_w) b_ph_q[0]    <= wbyte_w & `LBS_PHASE_MASK;
            if (hit_p2_w) b_ph_q[1]    <= wbyte_w & `LBS_PHASE_MASK;
            if (hit_p3_w) b_ph_q[2]    <= wbyte_w & `LBS_PHASE_MASK;
            if (hit_p4_w) b_ph_q[3]    <= wbyte_w & `LBS_PHASE_MASK;
            if (hit_du_w) a_duty_q     <= wbyte_w & `LBS_DUTY_MASK;
            if (hit_pe_w) a_period_q   <= wbyte_w & `LBS_PHASE_MASK;
        end
    end

    // ----------------------------------------------------------------
    // shared ticks
    // ----------------------------------------------------------------
    logic [31:0] step_cnt_q;
    logic [31:0] slot_cnt_q;
    wire         step_tick_w = (step_cnt_q == STEP_CYCLES - 1);
    wire         slot_tick_w = (slot_cnt_q == SLOT_CYCLES - 1);

    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            step_cnt_q <= 32'h0;
            slot_cnt_q <= 32'h0;
        end else begin
            step_cnt_q <= step_tick_w ? 32'h0 : step_cnt_q + 32'h1;
            slot_cnt_q <= slot_tick_w ? 32'h0 : slot_cnt_q + 32'h1;
        end
    end

    // ----------------------------------------------------------------
    // channel a: pattern period, on window and pwm
    // ----------------------------------------------------------------
    logic [6:0] a_per_cnt_q;
    logic [4:0] a_slot_q;
    wire        a_per_end_w = (a_per_cnt_q >= a_period_q[6:0]);
    wire        a_in_on_w   = ({2'b00, a_on_dur_q[4:0]} > a_per_cnt_q);
    wire        a_pwm_hi_w  = (a_slot_q <= a_duty_q[4:0]);

    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            a_per_cnt_q           <= 7'h00;
            a_slot_q              <= 5'h00;
            chan_a_drive_signal_o <= 1'b0;
        end else begin
            if (step_tick_w)
                a_per_cnt_q <= a_per_end_w ? 7'h00 : a_per_cnt_q + 7'h01;
            if (slot_tick_w)
                a_slot_q <= a_slot_q + 5'h01;
            chan_a_drive_signal_o <= a_in_on_w & a_pwm_hi_w;
        end
    end

    // ----------------------------------------------------------------
    // channel b: four phase sequence
    // ----------------------------------------------------------------
    lbs_phase_t ph_q;
    lbs_phase_t ph_nx_w;
    logic [6:0] ph_cnt_q;
    logic [1:0] ph_idx_w;
    logic [1:0] nx_idx_w;
    logic [6:0] ph_len_w;
    logic       ph_done_w;

    assign ph_idx_w  = 2'(ph_q - LBS_PH1);
    assign ph_len_w  = (ph_q == LBS_IDLE) ? 7'h00 : b_ph_q[ph_idx_w][6:0];
    // zero length phases end at once without waiting for a tick
    assign ph_done_w = (ph_len_w == 7'h00) | (step_tick_w & (ph_cnt_q + 7'h01 >= ph_len_w));
    assign nx_idx_w  = ph_idx_w + 2'b01;
    assign ph_nx_w   = lbs_phase_t'({1'b0, nx_idx_w} + 3'b001);

    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            ph_q     <= LBS_IDLE;
            ph_cnt_q <= 7'h00;
        end else begin
            unique case (ph_q)
                LBS_IDLE: begin
                    ph_q     <= LBS_PH1;
                    ph_cnt_q <= 7'h00;
                end
                LBS_PH1, LBS_PH2, LBS_PH3, LBS_PH4: begin
                    if (ph_done_w) begin
                        ph_q     <= ph_nx_w;
                        ph_cnt_q <= 7'h00;
                    end else if (step_tick_w) begin
                        ph_cnt_q <= ph_cnt_q + 7'h01;
                    end
                end
                default: begin
                    ph_q     <= LBS_IDLE;
                    ph_cnt_q <= 7'h00;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // outputs and apb read path
    // ----------------------------------------------------------------
    assign chan_b_sink_level_o = b_ramp_cur_q[3:0];
    assign chan_b_ramp_on_o    = b_ramp_cur_q[`LBS_RAMP_BIT];
    assign chan_b_phase_o      = ph_q;
    assign pready_o            = 1'b1;
    assign pslverr_o           = acc_w & ~mapped_w;

    wire [7:0] status_w = {4'h0, chan_a_drive_signal_o, ph_q};
    wire [7:0] rbyte_w  = hit_on_w ? a_on_dur_q   :
                          hit_rc_w ? b_ramp_cur_q :
                          hit_p1_w ? b_ph_q[0]    :
                          hit_p2_w ? b_ph_q[1]    :
                          hit_p3_w ? b_ph_q[2]    :
                          hit_p4_w ? b_ph_q[3]    :
                          hit_du_w ? a_duty_q     :
                          hit_pe_w ? a_period_q   :
                          hit_st_w ? status_w     : 8'h00;
    assign prdata_o = {24'h000000, rbyte_w};

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!resetn_i);

    chk_rsvd_on_dur: assert property (a_on_dur_q[7:5] == 3'b000)
        else $error("on-duration reserved bits set");
    chk_rsvd_phase: assert property (b_ph_q[0][7] == 1'b0 && b_ph_q[3][7] == 1'b0)
        else $error("phase reserved bit set");
    chk_on_dur_write: assert property (wr_w && hit_on_w |=> a_on_dur_q == ($past(pwdata_i[7:0]) & 8'h1F))
        else $error("on-duration write wrong");
    chk_ramp_output: assert property (wr_w && hit_rc_w |=> chan_b_ramp_on_o == $past(pwdata_i[5]))
        else $error("ramp enable not forwarded");
    chk_sink_level: assert property (wr_w && hit_rc_w |=> chan_b_sink_level_o == $past(pwdata_i[3:0]))
        else $error("sink level not forwarded");
    chk_phase1_write: assert property (wr_w && hit_p1_w |=> b_ph_q[0] == ($past(pwdata_i[7:0]) & 8'h7F))
        else $error("phase one write wrong");
    chk_phase2_zero_skip: assert property (ph_q == LBS_PH2 && b_ph_q[1] == 8'h00 |=> ph_q == LBS_PH3)
        else $error("empty phase two not skipped");
    chk_phase3_hold: assert property (ph_q == LBS_PH3 && !ph_done_w |=> ph_q == LBS_PH3)
        else $error("phase three left early");
    chk_phase4_wrap: assert property (ph_q == LBS_PH4 && ph_done_w |=> ph_q == LBS_PH1)
        else $error("phase four did not wrap");
    chk_pwm_full_duty: assert property (a_duty_q == 8'h1F && a_in_on_w |=> chan_a_drive_signal_o)
        else $error("full duty not continuous");
    chk_period_wrap: assert property (step_tick_w && a_per_end_w |=> a_per_cnt_q == 7'h00)
        else $error("pattern period did not wrap");
    chk_unmapped_err: assert property (acc_w && !mapped_w |-> pslverr_o && prdata_o == 32'h0)
        else $error("unmapped access not flagged");
    chk_rsvd_ramp: assert property (b_ramp_cur_q[7:6] == 2'b00 && b_ramp_cur_q[4] == 1'b0)
        else $error("ramp register reserved bits set");
    chk_rsvd_phase_mid: assert property (b_ph_q[1][7] == 1'b0 && b_ph_q[2][7] == 1'b0)
        else $error("middle phase reserved bit set");
    chk_rsvd_duty: assert property (a_duty_q[7:5] == 3'b000)
        else $error("duty reserved bits set");
    chk_strobe_off: assert property (acc_w && pwrite_i && !pstrb_i[0] && hit_on_w |=> $stable(a_on_dur_q))
        else $error("write without low lane strobe landed");
    chk_zero_len_skip: assert property (ph_q != LBS_IDLE && ph_len_w == 7'h00 |=> ph_q == $past(ph_nx_w))
        else $error("zero length phase not skipped");
    chk_idle_once: assert property (ph_q == LBS_IDLE |=> ph_q == LBS_PH1)
        else $error("idle state held past one cycle");

    cov_zero_skip:   cover property (ph_q == LBS_PH3 && ph_len_w == 7'h00);

    cov_phase_wrap:  cover property (ph_q == LBS_PH4 ##1 ph_q == LBS_PH1);
    cov_drive_rise:  cover property ($rose(chan_a_drive_signal_o));
    cov_ramp_write:  cover property (wr_w && hit_rc_w && pwdata_i[5]);

endmodule

/* File: include/lbs_params.svh */
// register offsets, field positions and timing counts for the led blink sequencer
`ifndef LBS_PARAMS_SVH
`define LBS_PARAMS_SVH

// ----------------------------------------------------------------
// register indices (byte address = index * 4)
// ----------------------------------------------------------------
`define LBS_IDX_A_ON_DUR    8'h4E
`define LBS_IDX_B_RAMP_CUR  8'h4F
`define LBS_IDX_B_PH1       8'h50
`define LBS_IDX_B_PH2       8'h51
`define LBS_IDX_B_PH3       8'h52
`define LBS_IDX_B_PH4       8'h53
`define LBS_IDX_A_DUTY      8'h54
`define LBS_IDX_A_PERIOD    8'h55
`define LBS_IDX_STATUS      8'h56

// ----------------------------------------------------------------
// field layout and reset values
// ----------------------------------------------------------------
`define LBS_ON_DUR_MASK     8'h1F
`define LBS_RAMP_BIT        5
`define LBS_RAMP_CUR_MASK   8'h2F
`define LBS_PHASE_MASK      8'h7F
`define LBS_DUTY_MASK       8'h1F
`define LBS_REG_RESET       8'h00

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define LBS_CLK_HZ          100000000
`define LBS_STEP_MS         64
`define LBS_PWM_PERIOD_MS   8
`define LBS_PWM_SLOTS       32
`define LBS_STEP_CYCLES     ((`LBS_CLK_HZ / 1000) * `LBS_STEP_MS)
`define LBS_SLOT_CYCLES     (((`LBS_CLK_HZ / 1000) * `LBS_PWM_PERIOD_MS) / `LBS_PWM_SLOTS)

`endif

/* File: include/lbs_pkg.sv */
// types for the led blink sequencer
package lbs_pkg;
    typedef enum logic [2:0] {
        LBS_IDLE = 3'b000,
        LBS_PH1  = 3'b001,
        LBS_PH2  = 3'b010,
        LBS_PH3  = 3'b011,
        LBS_PH4  = 3'b100
    } lbs_phase_t;
endpackage

/* File: verification/tb_lbs_sequencer.sv */
// self-checking testbench for the led blink sequencer register block
`timescale 1ns/1ps
`include "lbs_params.svh"
module tb_lbs_sequencer import lbs_pkg::*; ();
    localparam int unsigned STEP = 64;
    localparam int unsigned SLOT = 4;
    logic        ref_clk_i;
    logic        resetn_i;
    logic        psel_i;
    logic        penable_i;
    logic        pwrite_i;
    logic [11:0] paddr_i;
    logic [31:0] pwdata_i;
    logic [3:0]  pstrb_i;
    logic [31:0] prdata_o;
    logic        pready_o;
    logic        pslverr_o;
    logic        chan_a_drive_signal_o;
    logic [3:0]  chan_b_sink_level_o;
    logic        chan_b_ramp_on_o;
    logic [2:0]  chan_b_phase_o;
    int          bad_count;
    int          num_checks;

    lbs_sequencer #(.STEP_CYCLES(STEP), .SLOT_CYCLES(SLOT)) dut (
        .ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .psel_i(psel_i), .penable_i(penable_i),
        .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pstrb_i(pstrb_i),
        .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
        .chan_a_drive_signal_o(chan_a_drive_signal_o), .chan_b_sink_level_o(chan_b_sink_level_o),
        .chan_b_ramp_on_o(chan_b_ramp_on_o), .chan_b_phase_o(chan_b_phase_o));

    // ----------------------------------------------------------------
    // shared tasks
    // ----------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        num_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("Error at %0t ns: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] idx, input logic [31:0] d, input logic [3:0] s,
                       output logic [31:0] rd, output logic err);
        @(posedge ref_clk_i);
        psel_i <= 1'b1; penable_i <= 1'b0; pwrite_i <= w;
        paddr_i <= {2'b00, idx, 2'b00}; pwdata_i <= d; pstrb_i <= s;
        @(posedge ref_clk_i);
        penable_i <= 1'b1;
        do @(posedge ref_clk_i); while (pready_o !== 1'b1);
        rd = prdata_o;
        err = pslverr_o;
        psel_i <= 1'b0; penable_i <= 1'b0;
        // let the register update settle before callers look at outputs
        @(negedge ref_clk_i);
    endtask

    task automatic wr(input logic [7:0] idx, input logic [31:0] d);
        logic [31:0] rd;
        logic        err;
        apb(1'b1, idx, d, 4'hF, rd, err);
    endtask

    task automatic rd_chk(input logic [7:0] idx, input logic [31:0] exp, input string what);
        logic [31:0] rd;
        logic        err;
        apb(1'b0, idx, 32'h0000_0000, 4'h0, rd, err);
        check(rd, exp, what);
    endtask

    task automatic count_high(input int n, output int h);
        h = 0;
        repeat (n) begin
            @(negedge ref_clk_i);
            if (chan_a_drive_signal_o === 1'b1) h++;
        end
    endtask

    // time one phase from entry to exit, return length and following phase
    task automatic time_phase(input logic [2:0] p, output int d, output logic [2:0] nxt);
        d = 0;
        while (chan_b_phase_o !== p) @(negedge ref_clk_i);
        while (chan_b_phase_o === p) begin
            d++;
            @(negedge ref_clk_i);
        end
        nxt = chan_b_phase_o;
    endtask

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic test_fields();
        logic [7:0]  mask [6] = '{8'h1F, 8'h2F, 8'h7F, 8'h7F, 8'h7F, 8'h7F};
        logic [31:0] rd;
        logic        err;
        for (int i = 0; i < 6; i++) begin
            wr(8'h4E + 8'(i), 32'hFFFF_FFFF);
            rd_chk(8'h4E + 8'(i), {24'h00_0000, mask[i]}, "masked readback");
            apb(1'b1, 8'h4E + 8'(i), 32'h0000_0000, 4'hE, rd, err);
            rd_chk(8'h4E + 8'(i), {24'h00_0000, mask[i]}, "low lane strobe off");
        end
        wr(`LBS_IDX_B_RAMP_CUR, 32'h0000_0020);
        check({31'h0, chan_b_ramp_on_o}, 32'h1, "ramp on");
        check({28'h0, chan_b_sink_level_o}, 32'h0, "sink level zero");
        wr(`LBS_IDX_B_RAMP_CUR, 32'h0000_00DA);
        check({31'h0, chan_b_ramp_on_o}, 32'h0, "ramp off");
        check({28'h0, chan_b_sink_level_o}, 32'hA, "sink level");
        apb(1'b0, 8'h57, 32'h0, 4'h0, rd, err);
        check({rd[30:0], err}, 32'h1, "unmapped read");
        $display("test fields done");
    endtask

    task automatic test_phases();
        int         d;
        logic [2:0] nxt;
        wr(`LBS_IDX_B_PH1, 32'h01);
        wr(`LBS_IDX_B_PH2, 32'h02);
        wr(`LBS_IDX_B_PH3, 32'h00);
        wr(`LBS_IDX_B_PH4, 32'h03);
        time_phase(LBS_PH1, d, nxt);
        time_phase(LBS_PH2, d, nxt);
        check(32'(d), 32'(2 * STEP), "phase two length");
        check({29'h0, nxt}, {29'h0, LBS_PH3}, "after phase two");
        time_phase(LBS_PH3, d, nxt);
        check(32'(d), 32'h1, "zero phase skipped");
        time_phase(LBS_PH4, d, nxt);
        check({31'h0, d > 2 * STEP && d <= 3 * STEP}, 32'h1, "phase four length");
        check({29'h0, nxt}, {29'h0, LBS_PH1}, "wrap to phase one");
        time_phase(LBS_PH1, d, nxt);
        check(32'(d), 32'(STEP), "phase one length");
        $display("test phases done");
    endtask

    task automatic test_pwm();
        int         h;
        logic [4:0] duty [3] = '{5'h00, 5'h0F, 5'h1F};
        wr(`LBS_IDX_A_PERIOD, 32'h03);
        wr(`LBS_IDX_A_DUTY, 32'h1F);
        wr(`LBS_IDX_A_ON_DUR, 32'h02);
        count_high(4 * STEP, h);
        count_high(8 * STEP, h);
        check(32'(h), 32'(4 * STEP), "on window two of four steps");
        wr(`LBS_IDX_A_ON_DUR, 32'h00);
        count_high(4 * STEP, h);
        count_high(4 * STEP, h);
        check(32'(h), 32'h0, "zero on duration");
        wr(`LBS_IDX_A_ON_DUR, 32'h1F);
        for (int i = 0; i < 3; i++) begin
            wr(`LBS_IDX_A_DUTY, {27'h0, duty[i]});
            count_high(4 * STEP, h);
            count_high(32 * SLOT, h);
            check(32'(h), 32'((duty[i] + 1) * SLOT), "pwm high slots");
        end
        $display("test pwm done");
    endtask

    task automatic test_reset();
        for (int i = 0; i < 8; i++) wr(8'h4E + 8'(i), 32'h0000_00FF);
        @(posedge ref_clk_i);
        resetn_i <= 1'b0;
        repeat (3) @(posedge ref_clk_i);
        resetn_i <= 1'b1;
        for (int i = 0; i < 8; i++) begin
            rd_chk(8'h4E + 8'(i), 32'h0000_0000, "cleared by reset");
        end
        $display("test reset done");
    endtask

    // ----------------------------------------------------------------
    // clock, run control and watchdog
    // ----------------------------------------------------------------
    task automatic conclude();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    initial begin
        ref_clk_i = 1'b0;
        forever #5 ref_clk_i = ~ref_clk_i;
    end

    initial begin
        repeat (40000) @(posedge ref_clk_i);
        bad_count++;
        $display("Error at %0t ns: watchdog expired", $time);
        conclude();
    end

    initial begin
        resetn_i = 1'b0; psel_i = 1'b0; penable_i = 1'b0; pwrite_i = 1'b0;
        paddr_i = 12'h000; pwdata_i = 32'h0000_0000; pstrb_i = 4'h0;
        bad_count = 0; num_checks = 0;
        repeat (20) @(posedge ref_clk_i);
        resetn_i <= 1'b1;
        test_fields();
        test_phases();
        test_pwm();
        test_reset();
        conclude();
    end
endmodule
